// ### bdf_fifo.sv
`timescale 1ns/1ps
// Contract
// - two 512 by 18 queues, A to B and B to A, in write order
// - transfers only on a port clock rising edge qualified by enables
// - works with port clocks unrelated or identical
// - port A data driven only while select and write_not_read both low
// - port A write stores word when selected, writing, enabled, input ready high
// - port A read advances B to A queue when selected, reading, enabled, output ready
// - port B data driven only while select and write_not_read both low
// - port B write stores word when selected, writing, enabled, input ready high
// - port B read advances A to B queue when selected, reading, enabled, output ready
// - with both enables low, select changes only affect drive, not contents
// - ready flags pass two sync stages on their own port clock
// - input ready low when target queue full; writes then ignored
// - output ready low when source queue empty; reads then ignored
// - first word into empty queue loads output register as output ready rises
// - last word held on outputs after read empty until output ready rises
// - input ready low in queue reset, high on second write clock edge after
// - half full high at 256 or more words, low at 255 or fewer, low after reset
// - near limit high at 128 or fewer or 384 or more words, high in reset
module bdf_queue
    import bdf_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH,
    parameter int DEPTH = QUEUE_DEPTH
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic queue_reset_n,
    // write port
    input wire logic wr_tick,
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    // read port
    input wire logic rd_tick,
    input wire logic rd_req,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    // levels
    output bdf_level_type level
);
    localparam bdf_ptr_type DEPTH_P = PTR_WIDTH'(DEPTH);
    localparam bdf_ptr_type HALF_P = PTR_WIDTH'(HALF_LEVEL);
    localparam bdf_ptr_type NEAR_LO_P = PTR_WIDTH'(NEAR_EMPTY_OFFSET);
    localparam bdf_ptr_type NEAR_HI_P = PTR_WIDTH'(DEPTH - NEAR_FULL_OFFSET);

    // ****************************************
    // state
    // ****************************************
    logic [WIDTH-1:0] mem [DEPTH];
    bdf_ptr_type wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    bdf_ptr_type rd_gray_s1, next_rd_gray_s1, rd_gray_s2, next_rd_gray_s2;
    bdf_ptr_type wr_gray_s1, next_wr_gray_s1, wr_gray_s2, next_wr_gray_s2;
    logic [1:0] wr_arm, next_wr_arm;
    logic [1:0] ticks_seen, next_ticks_seen;
    logic out_valid, next_out_valid;
    logic [WIDTH-1:0] out_word, next_out_word;
    bdf_level_type lvl, next_lvl;
    logic clear, full, available, wr_fire, rd_fire;
    bdf_ptr_type fill;

    assign clear = ~reset_n | ~queue_reset_n;

    // ****************************************
    // next state
    // ****************************************
    // the flags see the far pointer only after two ticks of their own port,
    // so they are pessimistic: full may linger, empty may linger, never the reverse
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_rd_gray_s1 = rd_gray_s1;
        next_rd_gray_s2 = rd_gray_s2;
        next_wr_gray_s1 = wr_gray_s1;
        next_wr_gray_s2 = wr_gray_s2;
        next_wr_arm = wr_arm;
        next_out_valid = out_valid;
        next_out_word = out_word;
        next_ticks_seen = (wr_tick && ticks_seen != 2'h2) ? ticks_seen + 2'h1 : ticks_seen;
        full = (wr_ptr - bdf_gray2bin(rd_gray_s2)) >= DEPTH_P;
        wr_ready = wr_arm[1] & ~full;
        wr_fire = wr_tick & wr_valid & wr_ready;
        available = bdf_gray2bin(wr_gray_s2) != rd_ptr;
        rd_fire = rd_tick & rd_req & out_valid;
        if (wr_fire) begin
            next_wr_ptr = wr_ptr + 1'b1;
        end
        // write-side stages clocked by write port edges only
        if (wr_tick) begin
            next_rd_gray_s1 = bdf_bin2gray(rd_ptr);
            next_rd_gray_s2 = rd_gray_s1;
            next_wr_arm = {wr_arm[0], 1'b1};
        end
        if (rd_tick) begin
            next_wr_gray_s1 = bdf_bin2gray(wr_ptr);
            next_wr_gray_s2 = wr_gray_s1;
            if ((~out_valid | rd_fire) & available) begin
                next_out_word = mem[rd_ptr[PTR_WIDTH-2:0]];
                next_rd_ptr = rd_ptr + 1'b1;
                next_out_valid = 1'b1;
            end else if (rd_fire) begin
                next_out_valid = 1'b0;
            end
        end
        // level counts every word not yet handed to the reader
        fill = wr_ptr - rd_ptr;
        next_lvl.half_full = fill >= HALF_P;
        next_lvl.near_limit = (fill <= NEAR_LO_P) | (fill >= NEAR_HI_P);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (clear) begin
            wr_ptr <= PTR_RESET;
            rd_ptr <= PTR_RESET;
            rd_gray_s1 <= PTR_RESET;
            rd_gray_s2 <= PTR_RESET;
            wr_gray_s1 <= PTR_RESET;
            wr_gray_s2 <= PTR_RESET;
            wr_arm <= ARM_RESET;
            ticks_seen <= ARM_RESET;
            out_valid <= 1'b0;
            lvl.half_full <= HALF_RESET;
            lvl.near_limit <= NEAR_RESET;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            rd_gray_s1 <= next_rd_gray_s1;
            rd_gray_s2 <= next_rd_gray_s2;
            wr_gray_s1 <= next_wr_gray_s1;
            wr_gray_s2 <= next_wr_gray_s2;
            wr_arm <= next_wr_arm;
            ticks_seen <= next_ticks_seen;
            out_valid <= next_out_valid;
            lvl <= next_lvl;
        end
    end

    // output word survives queue reset so the bus never sees garbage
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            out_word <= '0;
        end else if (queue_reset_n) begin
            out_word <= next_out_word;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge sys_clk) begin
        if (wr_fire) begin
            mem[wr_ptr[PTR_WIDTH-2:0]] <= wr_data;
        end
    end

    assign rd_valid = out_valid;
    assign rd_data = out_word;
    assign level = lvl;

    // ****************************************
    // checks
    // ****************************************
    property p_write_ignored_full;
        @(posedge sys_clk) disable iff (clear)
        (wr_tick & wr_valid & ~wr_ready) |=> (wr_ptr == $past(wr_ptr));
    endproperty
    a_write_ignored_full: assert property (p_write_ignored_full) else $error("write taken while not ready");

    property p_write_stores;
        @(posedge sys_clk) disable iff (clear)
        wr_fire |=> (wr_ptr == $past(wr_ptr) + 1'b1);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("accepted write did not advance");

    property p_hold_when_empty;
        @(posedge sys_clk) disable iff (clear)
        (~out_valid & ~next_out_valid) |=> $stable(out_word);
    endproperty
    a_hold_when_empty: assert property (p_hold_when_empty) else $error("output word changed while empty");

    property p_load_on_rise;
        @(posedge sys_clk) disable iff (clear)
        $rose(out_valid) |-> (rd_ptr == $past(rd_ptr) + 1'b1);
    endproperty
    a_load_on_rise: assert property (p_load_on_rise) else $error("output ready rose without a load");

    property p_ready_after_reset;
        @(posedge sys_clk) disable iff (clear)
        (ticks_seen != 2'h2) |-> ~wr_ready;
    endproperty
    a_ready_after_reset: assert property (p_ready_after_reset) else $error("input ready too early");

    property p_arm_two_ticks;
        @(posedge sys_clk) disable iff (clear)
        wr_ready |-> (wr_arm == 2'h3);
    endproperty
    a_arm_two_ticks: assert property (p_arm_two_ticks) else $error("input ready before two edges");

    property p_reset_levels;
        @(posedge sys_clk)
        clear |=> (level.near_limit & ~level.half_full);
    endproperty
    a_reset_levels: assert property (p_reset_levels) else $error("level flags wrong in reset");

    property p_half_level;
        @(posedge sys_clk) disable iff (clear)
        ##1 (level.half_full == ($past(wr_ptr - rd_ptr) >= HALF_P));
    endproperty
    a_half_level: assert property (p_half_level) else $error("half full disagrees with fill");

    property p_read_ignored_empty;
        @(posedge sys_clk) disable iff (clear)
        (rd_tick & rd_req & ~out_valid & ~available) |=> (rd_ptr == $past(rd_ptr) && !out_valid);
    endproperty
    a_read_ignored_empty: assert property (p_read_ignored_empty) else $error("read taken while empty");
endmodule

module bdf_fifo
    import bdf_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // queue resets, active low
    input wire logic a_to_b_queue_reset_n,
    input wire logic b_to_a_queue_reset_n,
    // port clocks, sampled on sys_clk
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    // port controls
    input wire bdf_port_ctrl_type port_a_ctrl,
    input wire bdf_port_ctrl_type port_b_ctrl,
    // port A data pins
    input wire bdf_word_type port_a_data_in,
    output bdf_word_type port_a_data_out,
    output logic port_a_data_oe,
    // port B data pins
    input wire bdf_word_type port_b_data_in,
    output bdf_word_type port_b_data_out,
    output logic port_b_data_oe,
    // flags
    output logic port_a_input_ready,
    output logic port_a_output_ready,
    output logic port_b_input_ready,
    output logic port_b_output_ready,
    output bdf_level_type a_to_b_level,
    output bdf_level_type b_to_a_level
);
    // ****************************************
    // port clock edge ticks
    // ****************************************
    logic a_clk_last, next_a_clk_last, b_clk_last, next_b_clk_last;
    logic a_tick, b_tick;
    logic a_write, a_read, b_write, b_read;

    // each port clock becomes a one-cycle tick, so equal or unrelated clocks look alike
    always_comb begin
        next_a_clk_last = port_a_clock;
        next_b_clk_last = port_b_clock;
        a_tick = port_a_clock & ~a_clk_last;
        b_tick = port_b_clock & ~b_clk_last;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            a_clk_last <= 1'b1;
            b_clk_last <= 1'b1;
        end else begin
            a_clk_last <= next_a_clk_last;
            b_clk_last <= next_b_clk_last;
        end
    end

    // ****************************************
    // port decode
    // ****************************************
    // selects alone never reach the queues; only enables do
    assign a_write = ~port_a_ctrl.select_n & port_a_ctrl.write_not_read & port_a_ctrl.write_enable;
    assign a_read = ~port_a_ctrl.select_n & ~port_a_ctrl.write_not_read & port_a_ctrl.read_enable;
    assign b_write = ~port_b_ctrl.select_n & port_b_ctrl.write_not_read & port_b_ctrl.write_enable;
    assign b_read = ~port_b_ctrl.select_n & ~port_b_ctrl.write_not_read & port_b_ctrl.read_enable;
    assign port_a_data_oe = ~port_a_ctrl.select_n & ~port_a_ctrl.write_not_read;
    assign port_b_data_oe = ~port_b_ctrl.select_n & ~port_b_ctrl.write_not_read;

    // ****************************************
    // the two queues
    // ****************************************
    bdf_queue #(.WIDTH(DATA_WIDTH), .DEPTH(QUEUE_DEPTH)) u_queue_a_to_b (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .queue_reset_n(a_to_b_queue_reset_n),
        .wr_tick(a_tick),
        .wr_valid(a_write),
        .wr_data(port_a_data_in),
        .wr_ready(port_a_input_ready),
        .rd_tick(b_tick),
        .rd_req(b_read),
        .rd_valid(port_b_output_ready),
        .rd_data(port_b_data_out),
        .level(a_to_b_level)
    );

    bdf_queue #(.WIDTH(DATA_WIDTH), .DEPTH(QUEUE_DEPTH)) u_queue_b_to_a (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .queue_reset_n(b_to_a_queue_reset_n),
        .wr_tick(b_tick),
        .wr_valid(b_write),
        .wr_data(port_b_data_in),
        .wr_ready(port_b_input_ready),
        .rd_tick(a_tick),
        .rd_req(a_read),
        .rd_valid(port_a_output_ready),
        .rd_data(port_a_data_out),
        .level(b_to_a_level)
    );

    // ****************************************
    // checks
    // ****************************************
    property p_a_drive;
        @(posedge sys_clk) disable iff (!reset_n)
        port_a_data_oe |-> (!port_a_ctrl.select_n && !port_a_ctrl.write_not_read && !a_write);
    endproperty
    a_a_drive: assert property (p_a_drive) else $error("port A driven while not reading");

    property p_b_drive;
        @(posedge sys_clk) disable iff (!reset_n)
        port_b_data_oe |-> (!port_b_ctrl.select_n && !port_b_ctrl.write_not_read && !b_write);
    endproperty
    a_b_drive: assert property (p_b_drive) else $error("port B driven while not reading");
endmodule

// ### bdf_pkg.sv
package bdf_pkg;

    // ****************************************
    // sizes and levels
    // ****************************************
    localparam int DATA_WIDTH = 18;
    localparam int QUEUE_DEPTH = 512;
    localparam int PTR_WIDTH = 10;
    localparam int HALF_LEVEL = 256;
    localparam int NEAR_EMPTY_OFFSET = 128;
    localparam int NEAR_FULL_OFFSET = 128;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [PTR_WIDTH-1:0] PTR_RESET = 10'h000;
    localparam logic [1:0] ARM_RESET = 2'h0;
    localparam logic HALF_RESET = 1'b0;
    localparam logic NEAR_RESET = 1'b1;

    // ****************************************
    // carriers
    // ****************************************
    typedef logic [DATA_WIDTH-1:0] bdf_word_type;
    typedef logic [PTR_WIDTH-1:0] bdf_ptr_type;

    typedef struct packed {
        logic select_n;
        logic write_not_read;
        logic write_enable;
        logic read_enable;
    } bdf_port_ctrl_type;

    typedef struct packed {
        logic half_full;
        logic near_limit;
    } bdf_level_type;

    // ****************************************
    // gray code helpers
    // ****************************************
    function automatic bdf_ptr_type bdf_bin2gray(input bdf_ptr_type bin);
        return bin ^ (bin >> 1);
    endfunction

    function automatic bdf_ptr_type bdf_gray2bin(input bdf_ptr_type gray);
        bdf_ptr_type bin;
        bin[PTR_WIDTH-1] = gray[PTR_WIDTH-1];
        for (int i = PTR_WIDTH - 2; i >= 0; i--) begin
            bin[i] = bin[i+1] ^ gray[i];
        end
        return bin;
    endfunction

endpackage

// ### bdf_port_host.sv
`timescale 1ns/1ps
module bdf_port_host
    import bdf_pkg::*;
#(
    parameter int HALF = 2
) (
    // system clock
    input wire logic sys_clk,
    // port pins
    output logic port_clock,
    output bdf_port_ctrl_type ctrl,
    output bdf_word_type data_drv,
    input wire bdf_word_type pin_data,
    // flags
    input wire logic input_ready,
    input wire logic output_ready
);
    int cnt = 0;

    // ****************************************
    // free running port clock
    // ****************************************
    initial begin
        port_clock = 1'b0;
        ctrl = bdf_port_ctrl_type'(4'b1000);
        data_drv = 18'h0_0000;
    end

    // runs even when idle, the port never stops its clock
    always @(posedge sys_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            port_clock <= #1 ~port_clock;
        end
    end

    // ****************************************
    // bus cycles, controls change just after a port clock rise, in shuffle just after a system clock rise
    // ****************************************
    // ctrl bits: select_n, write_not_read, write_enable, read_enable
    // write is only counted when input ready is high at that tick
    task automatic write_word(input bdf_word_type w, output logic ok);
        @(posedge port_clock);
        ctrl = bdf_port_ctrl_type'(4'b0110);
        data_drv = w;
        ok = input_ready;
    endtask

    // data taken only with output ready high; wait lets the pins settle
    task automatic read_word(output bdf_word_type w, output logic ok);
        @(posedge port_clock);
        ctrl = bdf_port_ctrl_type'(4'b0001);
        #1;
        ok = output_ready;
        w = pin_data;
    endtask

    // released bus shows a changing pattern, not the last word
    task automatic idle();
        @(posedge port_clock);
        ctrl = bdf_port_ctrl_type'(4'b1000);
        data_drv = ~data_drv;
    endtask

    // select lines wander at any time while both enables stay low
    task automatic shuffle(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            ctrl = bdf_port_ctrl_type'({2'($urandom_range(3)), 2'b00});
        end
    endtask
endmodule

// ### bidirectional_dual_clock_fifo_tb_top.sv
`timescale 1ns/1ps
module bidirectional_dual_clock_fifo_tb_top import bdf_pkg::*; ();
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ab_rst_n = 1'b1;
    logic ba_rst_n = 1'b1;
    logic clk_a, clk_b, oe_a, oe_b, ir_a, or_a, ir_b, or_b, ok, ok_a, ok_b;
    bdf_port_ctrl_type ctrl_a, ctrl_b;
    bdf_word_type drv_a, drv_b, out_a, out_b, pin_a, pin_b;
    bdf_level_type lvl_ab, lvl_ba;
    bdf_word_type q_ab[$];
    bdf_word_type q_ba[$];
    bdf_word_type last_ab = 18'h0_0000;
    bdf_word_type last_ba = 18'h0_0000;
    int err_total = 0;
    int tests_run = 0;
    int n;

    // ****************************************
    // pins, clock and instances
    // ****************************************
    // the device wins the pins when it drives, else the host pattern
    assign pin_a = oe_a ? out_a : drv_a;
    assign pin_b = oe_b ? out_b : drv_b;

    initial forever #2.5 sys_clk = ~sys_clk;

    bdf_fifo u_bdf_fifo (.sys_clk(sys_clk), .reset_n(reset_n), .a_to_b_queue_reset_n(ab_rst_n),
        .b_to_a_queue_reset_n(ba_rst_n), .port_a_clock(clk_a), .port_b_clock(clk_b),
        .port_a_ctrl(ctrl_a), .port_b_ctrl(ctrl_b), .port_a_data_in(pin_a), .port_a_data_out(out_a),
        .port_a_data_oe(oe_a), .port_b_data_in(pin_b), .port_b_data_out(out_b), .port_b_data_oe(oe_b),
        .port_a_input_ready(ir_a), .port_a_output_ready(or_a), .port_b_input_ready(ir_b),
        .port_b_output_ready(or_b), .a_to_b_level(lvl_ab), .b_to_a_level(lvl_ba));
    // unequal port rates keep the two sides unrelated
    bdf_port_host #(.HALF(2)) u_bdf_port_host_a (.sys_clk(sys_clk), .port_clock(clk_a), .ctrl(ctrl_a),
        .data_drv(drv_a), .pin_data(pin_a), .input_ready(ir_a), .output_ready(or_a));
    bdf_port_host #(.HALF(3)) u_bdf_port_host_b (.sys_clk(sys_clk), .port_clock(clk_b), .ctrl(ctrl_b),
        .data_drv(drv_b), .pin_data(pin_b), .input_ready(ir_b), .output_ready(or_b));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // model queue only grows on an accepted write
    task automatic put(input bit ab, output logic ok_o);
        bdf_word_type w;
        w = bdf_word_type'($urandom);
        if (ab) u_bdf_port_host_a.write_word(w, ok_o);
        else u_bdf_port_host_b.write_word(w, ok_o);
        if (ok_o === 1'b1 && ab) q_ab.push_back(w);
        if (ok_o === 1'b1 && !ab) q_ba.push_back(w);
    endtask

    task automatic get(input bit ab, output logic ok_o);
        bdf_word_type w;
        bdf_word_type exp;
        if (ab) u_bdf_port_host_b.read_word(w, ok_o);
        else u_bdf_port_host_a.read_word(w, ok_o);
        if (ok_o === 1'b1) begin
            exp = ~w;
            if (ab && q_ab.size() > 0) exp = q_ab.pop_front();
            if (!ab && q_ba.size() > 0) exp = q_ba.pop_front();
            if (ab) last_ab = exp;
            else last_ba = exp;
            check("word", exp, w);
        end else begin
            check("held word", ab ? last_ab : last_ba, w);
        end
    endtask

    // pause lets the pointers settle before the queue is emptied
    task automatic drain(input bit ab);
        u_bdf_port_host_a.idle();
        u_bdf_port_host_b.idle();
        repeat (20) @(posedge sys_clk);
        n = 0;
        ok = 1'b1;
        while (ok === 1'b1 && n < 600) begin
            get(ab, ok);
            n++;
        end
        // reader parks, so a standing read enable never swallows later words
        if (ab) u_bdf_port_host_b.idle();
        else u_bdf_port_host_a.idle();
        check("words left", 0, ab ? q_ab.size() : q_ba.size());
    endtask

    task automatic end_test(input string name);
        $display("test %s done, %0d mismatches so far", name, err_total);
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // pin drive follows the selects at every cycle
    always @(negedge sys_clk) begin
        check("a drive", !ctrl_a.select_n && !ctrl_a.write_not_read, oe_a);
        check("b drive", !ctrl_b.select_n && !ctrl_b.write_not_read, oe_b);
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        n = $urandom(32'hcc34d15c);
        repeat (10) @(posedge sys_clk);
        #1;
        check("ir in reset", 0, ir_a);
        check("a_to_b level in reset", 2'b01, lvl_ab);
        check("b_to_a level in reset", 2'b01, lvl_ba);
        reset_n = 1'b1;
        // each port mixes its writes and reads at random, then parks its bus
        fork
            begin
                repeat (80) if ($urandom_range(1)) put(1, ok_a); else get(0, ok_a);
                u_bdf_port_host_a.idle();
            end
            begin
                repeat (80) if ($urandom_range(1)) put(0, ok_b); else get(1, ok_b);
                u_bdf_port_host_b.idle();
            end
        join
        drain(1);
        drain(0);
        end_test("bidirectional");
        repeat (3) put(1, ok);
        u_bdf_port_host_a.idle();
        repeat (3) put(0, ok);
        fork
            u_bdf_port_host_a.shuffle(40);
            u_bdf_port_host_b.shuffle(40);
        join
        drain(1);
        drain(0);
        end_test("select shuffle");
        // fill with the reader idle; levels checked far from their limits
        n = 0;
        ok = 1'b1;
        while (ok === 1'b1 && n < 600) begin
            put(1, ok);
            n++;
            if (ok === 1'b1 && q_ab.size() inside {100, 200, 300}) begin
                u_bdf_port_host_a.idle();
                repeat (12) @(posedge sys_clk);
                check("level", {q_ab.size() >= HALF_LEVEL, q_ab.size() <= NEAR_EMPTY_OFFSET}, lvl_ab);
            end
        end
        check("capacity", 1, q_ab.size() >= QUEUE_DEPTH - 2 && q_ab.size() <= QUEUE_DEPTH + 1);
        repeat (3) put(1, ok);
        check("write refused", 0, ok);
        u_bdf_port_host_a.idle();
        repeat (12) @(posedge sys_clk);
        check("full level", 2'b11, lvl_ab);
        drain(1);
        end_test("fill and drain");
        repeat (5) put(1, ok);
        u_bdf_port_host_a.idle();
        @(posedge sys_clk);
        #1 ab_rst_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check("ir in queue reset", 0, ir_a);
        check("or in queue reset", 0, or_b);
        check("level in queue reset", 2'b01, lvl_ab);
        q_ab.delete();
        @(negedge clk_a);
        ab_rst_n = 1'b1;
        @(posedge clk_a);
        check("ir first rise", 0, ir_a);
        @(posedge clk_a);
        check("ir second rise", 0, ir_a);
        @(posedge clk_a);
        check("ir third rise", 1, ir_a);
        repeat (4) put(1, ok);
        drain(1);
        end_test("queue reset");
        final_report();
    end

    // a hang counts as a mismatch
    initial begin
        #300000;
        err_total++;
        $display("watchdog expired");
        final_report();
    end
endmodule
